/* File: tb/swl_peer.sv */
// Far-side link endpoint model that answers resets and injects frames
`timescale 1ns/1ps
module swl_peer
  import swl_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       mute,
  input  wire logic       tx_valid,
  input  wire swl_frame_s tx_frame,
  output logic            tx_ready,
  output logic            rx_valid,
  output swl_frame_s      rx_frame
);
  swl_frame_s sendq[$];
  swl_frame_s ua;

  task automatic send(input swl_frame_s f);
    sendq.push_back(f);
  endtask

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_frame <= '0;
    end
    else
    begin
      // Random stalls, so the sender must hold its frame
      tx_ready <= ($urandom % 4) != 0;
      if (tx_valid && tx_ready && !mute && tx_frame.kind == KIND_U && tx_frame.umod == UM_RSET)
      begin
        ua = '0;
        ua.kind = KIND_U;
        ua.umod = UM_UA;
        sendq.push_back(ua);
      end
      // Idle frame lines toggle, so stale fields never look valid
      if (rx_valid)
      begin
        rx_valid <= 1'b0;
        rx_frame <= ~rx_frame;
      end
      else if (sendq.size() != 0)
      begin
        rx_valid <= 1'b1;
        rx_frame <= sendq.pop_front();
      end
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the sliding-window link endpoint
`timescale 1ns/1ps
module tb_top
  import swl_pkg::*;
;
  logic        clock;
  logic        nrst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_w;
  logic [31:0] dat_r;
  logic        ack;
  logic        rx_valid;
  swl_frame_s  rx_frame;
  logic        tx_valid;
  swl_frame_s  tx_frame;
  logic        tx_ready;
  logic        rx_deliver;
  logic        link_reset;
  swl_link_e   link_state;
  logic        mute;
  logic [31:0] r;
  int          n;
  int          miscompares = 0;
  int          n_compared = 0;
  int          n_deliver = 0;
  int          n_reset = 0;
  swl_frame_s  expq[$];
  swl_frame_s  f;

  swl_endpoint #(.ACK_CYC_P(40), .GUARD_CYC_P(80), .CONN_CYC_P(39), .RR_CYC_P(40)) u_dut (
    .clock(clock), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .tx_valid(tx_valid), .tx_frame(tx_frame),
    .tx_ready(tx_ready), .rx_deliver(rx_deliver), .link_reset(link_reset),
    .link_state(link_state));

  swl_peer u_peer (
    .clock(clock), .nrst(nrst), .mute(mute), .tx_valid(tx_valid), .tx_frame(tx_frame),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_frame(rx_frame));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic swl_frame_s fr(swl_kind_e k, logic [2:0] ns, logic [2:0] nr,
                                    logic [1:0] st, logic [4:0] um);
    fr = '0;
    fr.kind = k;
    fr.ns = ns;
    fr.nr = nr;
    fr.stype = st;
    fr.umod = um;
    fr.win = DEF_WIN;
  endfunction

  // Only the fields that carry meaning for each frame kind
  function automatic logic [31:0] key(swl_frame_s f);
    key = {17'h0, f.kind, (f.kind == KIND_I) ? f.ns : 3'h0, (f.kind != KIND_U) ? f.nr : 3'h0,
           (f.kind == KIND_S) ? f.stype : 2'h0, (f.kind == KIND_U) ? f.umod : 5'h00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do @(posedge clock); while (ack !== 1'b1);
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic drain();
    n = 0;
    while (expq.size() != 0 && n < 3000)
    begin
      @(posedge clock);
      n++;
    end
    // A frame that never came counts as a mismatch
    if (expq.size() != 0)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, 32'h0, key(expq[0]));
      expq.delete();
    end
  endtask

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------
  always @(posedge clock)
  begin
    if (rx_deliver === 1'b1)
      n_deliver++;
    if (link_reset === 1'b1)
      n_reset++;
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      if (expq.size() == 0)
        chk(key(tx_frame), 32'h0000_1fff);
      else
        chk(key(tx_frame), key(expq.pop_front()));
    end
  end

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    {cyc, stb, we, adr, dat_w} = '0;
    sel = 4'hf;
    mute = 1'b1;
    void'($urandom(45228));
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    wb(1'b0, REG_STAT, 32'h0);
    chk(r, 32'h0000_2000);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(r, 32'h0000_0010);
    wb(1'b1, 8'hfc, 32'hffff_ffff);
    wb(1'b0, 8'hfc, 32'h0);
    chk(r, 32'h0000_0000);
    // frame before link up is dropped
    u_peer.send(fr(KIND_I, 3'h0, 3'h0, ST_RR, 5'h00));
    repeat (10) @(posedge clock);
    // Unanswered reset is retried
    expq.push_back(fr(KIND_I, 3'h0, 3'h0, 2'h0, UM_RSET));
    expq[0].kind = KIND_U;
    wb(1'b1, REG_CTRL, 32'h0000_0011);
    drain();
    expq.push_back(fr(KIND_U, 3'h0, 3'h0, 2'h0, UM_RSET));
    drain();
    chk(n >= 35 && n <= 45, 1);
    mute <= 1'b0;
    expq.push_back(fr(KIND_U, 3'h0, 3'h0, 2'h0, UM_RSET));
    drain();
    repeat (8) @(posedge clock);
    chk(link_state, LNK_UP);
    wb(1'b0, REG_STAT, 32'h0);
    chk(r, 32'h0000_2003);
    // Five queued, window of four stops the fifth
    for (int i = 0; i < 4; i++)
      expq.push_back(fr(KIND_I, i[2:0], 3'h0, 2'h0, 5'h00));
    wb(1'b1, REG_TXQ, 32'h0000_0005);
    drain();
    wb(1'b0, REG_STAT, 32'h0);
    chk(r, 32'h0000_2013);
    expq.push_back(fr(KIND_I, 3'h4, 3'h0, 2'h0, 5'h00));
    u_peer.send(fr(KIND_S, 3'h0, 3'h4, ST_RR, 5'h00));
    drain();
    // Lost last frame comes back after the guard time
    expq.push_back(fr(KIND_I, 3'h4, 3'h0, 2'h0, 5'h00));
    drain();
    chk(n > 75, 1);
    u_peer.send(fr(KIND_S, 3'h0, 3'h5, ST_RR, 5'h00));
    repeat (6) @(posedge clock);
    wb(1'b0, REG_STAT, 32'h0);
    chk(r, 32'h0000_2517);
    // Timed acknowledge, then a gap, then the missing frame
    expq.push_back(fr(KIND_S, 3'h0, 3'h1, ST_RR, 5'h00));
    u_peer.send(fr(KIND_I, 3'h0, 3'h5, 2'h0, 5'h00));
    drain();
    chk(n <= 50, 1);
    expq.push_back(fr(KIND_S, 3'h0, 3'h1, ST_REJ, 5'h00));
    u_peer.send(fr(KIND_I, 3'h2, 3'h5, 2'h0, 5'h00));
    drain();
    chk(n <= 12, 1);
    expq.push_back(fr(KIND_S, 3'h0, 3'h2, ST_RR, 5'h00));
    u_peer.send(fr(KIND_I, 3'h1, 3'h5, 2'h0, 5'h00));
    drain();
    // Peer offers a smaller window: adopted, answered with UA
    f = fr(KIND_U, 3'h0, 3'h0, 2'h0, UM_RSET);
    f.has_cfg = 1'b1;
    f.win = MIN_WIN;
    expq.push_back(fr(KIND_U, 3'h0, 3'h0, 2'h0, UM_UA));
    u_peer.send(f);
    drain();
    repeat (8) @(posedge clock);
    wb(1'b0, REG_STAT, 32'h0);
    chk(r, 32'h0000_1003);
    // Local window smaller: own reset instead of UA
    wb(1'b1, REG_CTRL, 32'h0000_0008);
    expq.push_back(fr(KIND_U, 3'h0, 3'h0, 2'h0, UM_RSET));
    u_peer.send(fr(KIND_U, 3'h0, 3'h0, 2'h0, UM_RSET));
    drain();
    repeat (8) @(posedge clock);
    chk(link_state, LNK_UP);
    // Peer pauses, then resumes with nothing queued here
    u_peer.send(fr(KIND_S, 3'h0, 3'h0, ST_RNR, 5'h00));
    repeat (4) @(posedge clock);
    wb(1'b0, REG_STAT, 32'h0);
    chk(r, 32'h0000_9003);
    expq.push_back(fr(KIND_I, 3'h0, 3'h0, 2'h0, 5'h00));
    u_peer.send(fr(KIND_S, 3'h0, 3'h0, ST_RR, 5'h00));
    drain();
    u_peer.send(fr(KIND_S, 3'h0, 3'h1, ST_RR, 5'h00));
    // Local busy turns the timed ack into RNR; resume RR repeats
    wb(1'b1, REG_CTRL, 32'h0000_000a);
    expq.push_back(fr(KIND_S, 3'h0, 3'h1, ST_RNR, 5'h00));
    u_peer.send(fr(KIND_I, 3'h0, 3'h1, 2'h0, 5'h00));
    drain();
    for (int i = 0; i < 2; i++)
      expq.push_back(fr(KIND_S, 3'h0, 3'h1, ST_RR, 5'h00));
    wb(1'b1, REG_CTRL, 32'h0000_0008);
    drain();
    expq.push_back(fr(KIND_S, 3'h0, 3'h2, ST_RR, 5'h00));
    u_peer.send(fr(KIND_I, 3'h1, 3'h1, 2'h0, 5'h00));
    drain();
    repeat (60) @(posedge clock);
    chk(n_deliver, 4);
    chk(n_reset, 3);
    conclude();
  end
endmodule

/* File: verilog/swl_endpoint.sv */
// Sliding-window link endpoint with a classic Wishbone register slave
//
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps

// Function
// R1 - Window four by default, fixed per session
// R2 - Acknowledge within 5 ms times w/4
// R3 - Retransmit after at least 10 ms guard
// R4 - Resend reset if no answer below 5 ms
// R5 - Send number modulo 8, bump after emission
// R6 - Every I and S frame carries nr
// R7 - Track oldest unacknowledged sequence number
// R8 - Window membership test done modulo 8
// R9 - Clear all sequence variables on establishment
// R10 - Establish link by sending reset first
// R11 - Reset on unrecoverable error, flush, inform
// R12 - Reply UA; sender up on UA
// R13 - Drop all but reset before link up
// R14 - Crossed resets: both reply UA
// R15 - Reset carries all requested settings together
// R16 - Smaller window ignores reset, sends own
// R17 - Ack timer sends RR, stopped by piggyback
// R18 - Gap detected sends REJ at once
// R19 - Retransmit timer covers every I-frame
// R20 - RNR pauses peer; resume RR repeats
// R21 - Resume RR with nothing queued: empty I
// R22 - Crossed protocol offers: front end sends UA
// R23 - Supervisory types RR REJ RNR SREJ
// R24 - Reset 11001, UA 00110 modifiers
// R25 - Offered window between two and four
// R26 - Accept I-frame only when ns equals nr
// R27 - Stop new frames when window full
module swl_endpoint
  import swl_pkg::*;
#(
  parameter int ACK_CYC_P   = ACK_CYC,
  parameter int GUARD_CYC_P = GUARD_CYC,
  parameter int CONN_CYC_P  = CONN_CYC,
  parameter int RR_CYC_P    = RR_RPT_CYC
)(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        rx_valid,
  input  wire swl_frame_s  rx_frame,
  output logic             tx_valid,
  output swl_frame_s       tx_frame,
  input  wire logic        tx_ready,
  output logic             rx_deliver,
  output logic             link_reset,
  output swl_link_e        link_state
);

  typedef struct packed {
    swl_link_e        lstate;
    logic [2:0]       win;
    logic             srej_ok;
    logic [2:0]       ns;
    logic [2:0]       nr;
    logic [2:0]       dnr;
    logic [2:0]       top;
    logic [3:0]       txq;
    logic             peer_busy;
    logic             rr_rpt;
    logic             busy_prev;
    logic [TMR_W-1:0] ack_t;
    logic [TMR_W-1:0] grd_t;
    logic [TMR_W-1:0] con_t;
    logic [TMR_W-1:0] rr_t;
    logic             pend_rset;
    logic             pend_ua;
    logic             pend_s;
    logic [1:0]       pend_stype;
    logic             pend_empty;
    logic             ua_up;
    logic             tx_valid;
    swl_frame_s       tx_frame;
    logic             wb_ack;
    logic [31:0]      wb_dat;
    logic             ctrl_busy;
    logic [2:0]       ctrl_win;
    logic             ctrl_srej;
    logic             ctrl_fe;
    logic             rx_deliver;
    logic             link_reset;
  } swl_state_s;

  swl_state_s s_q;
  swl_state_s s_d;

  // R8 window test
  function automatic logic in_win(input logic [2:0] x, input logic [2:0] y,
                                  input logic [2:0] z);
    if (x <= z)
      in_win = (x <= y) && (y < z);
    else
      in_win = (y >= x) || (y < z);
  endfunction

  // R25 clamp offered window
  function automatic logic [2:0] clamp_win(input logic [2:0] w);
    if (w < MIN_WIN)
      clamp_win = MIN_WIN;
    else if (w > DEF_WIN)
      clamp_win = DEF_WIN;
    else
      clamp_win = w;
  endfunction

  logic [2:0]       peer_win;
  logic [2:0]       outstanding;
  logic [TMR_W-1:0] ack_lim;
  logic             wb_req;

  assign peer_win    = rx_frame.has_cfg ? clamp_win(rx_frame.win) : DEF_WIN;
  assign outstanding = 3'(s_q.ns - s_q.dnr);
  // R2 scale by window
  assign ack_lim     = TMR_W'((ACK_CYC_P / 4) * int'(s_q.win));
  assign wb_req      = wb_cyc_i && wb_stb_i && !s_q.wb_ack;

  always_comb
  begin
    s_d = s_q;
    s_d.rx_deliver = 1'b0;
    s_d.link_reset = 1'b0;
    s_d.busy_prev  = s_q.ctrl_busy;
    if (s_q.ack_t != '0)
      s_d.ack_t = s_q.ack_t - 1'b1;
    if (s_q.grd_t != '0)
      s_d.grd_t = s_q.grd_t - 1'b1;
    if (s_q.con_t != '0)
      s_d.con_t = s_q.con_t - 1'b1;
    if (s_q.rr_t != '0)
      s_d.rr_t = s_q.rr_t - 1'b1;

    // ----------------------------------------------------------------
    // Transmit completion
    // ----------------------------------------------------------------
    if (s_q.tx_valid && tx_ready)
    begin
      s_d.tx_valid = 1'b0;
      case (s_q.tx_frame.kind)
        KIND_I:
        begin
          // R5 bump after emission
          s_d.ns = 3'(s_q.ns + 3'h1);
          if (s_q.ns == s_q.top)
          begin
            s_d.top = 3'(s_q.top + 3'h1);
            if (s_q.tx_frame.empty)
              s_d.pend_empty = 1'b0;
            else
              s_d.txq = 4'(s_q.txq - 4'h1);
          end
          // R19 guard every I-frame
          s_d.grd_t = TMR_W'(GUARD_CYC_P);
          // R17 piggyback stops ack timer
          s_d.ack_t = '0;
        end
        KIND_S:
          s_d.ack_t = '0;
        default:
        begin
          if (s_q.tx_frame.umod == UM_RSET)
            s_d.con_t = TMR_W'(CONN_CYC_P);
          else if (s_q.ua_up)
          begin
            s_d.lstate = LNK_UP;
            s_d.ua_up  = 1'b0;
          end
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    s_d.wb_ack = wb_req;
    s_d.wb_dat = '0;
    if (wb_req && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == REG_CTRL)
      begin
        s_d.ctrl_busy = wb_dat_i[CTRL_BUSY];
        s_d.ctrl_win  = clamp_win(wb_dat_i[CTRL_WIN_LSB +: 3]);
        s_d.ctrl_srej = wb_dat_i[CTRL_SREJ];
        s_d.ctrl_fe   = wb_dat_i[CTRL_FE];
        // R10 R11 start or restart with a reset frame
        if (wb_dat_i[CTRL_CONNECT])
        begin
          s_d.lstate     = LNK_WAIT;
          s_d.pend_rset  = 1'b1;
          s_d.link_reset = 1'b1;
          s_d.txq        = '0;
          s_d.top        = '0;
          s_d.ns         = '0;
        end
      end
      else if (wb_adr_i == REG_TXQ)
        s_d.txq = 4'(s_d.txq + wb_dat_i[3:0]);
    end
    else if (wb_req)
    begin
      case (wb_adr_i)
        REG_CTRL: s_d.wb_dat = 32'({s_q.ctrl_fe, s_q.ctrl_srej, s_q.ctrl_win,
                                    s_q.ctrl_busy, 1'b0});
        REG_TXQ:  s_d.wb_dat = 32'(s_q.txq);
        REG_STAT: s_d.wb_dat = 32'({s_q.peer_busy, s_q.srej_ok, s_q.win, s_q.dnr,
                                    s_q.nr, s_q.ns, s_q.lstate});
        default:  s_d.wb_dat = '0;
      endcase
    end

    // ----------------------------------------------------------------
    // Receive
    // ----------------------------------------------------------------
    if (rx_valid && rx_frame.kind == KIND_U && rx_frame.umod == UM_RSET)
    begin
      // R16 smaller local window: ignore, offer own
      if (s_q.ctrl_win < peer_win)
      begin
        // Own reset reopens establishment; up again on a UA, or after answering an acceptable reset with UA
        s_d.pend_rset = 1'b1;
        s_d.lstate    = LNK_WAIT;
        if (s_q.lstate == LNK_UP)
          s_d.link_reset = 1'b1;
      end
      else
      begin
        // R12 R14 R22 answer with UA, crossed or not; protocol lists unused
        s_d.win     = peer_win;
        s_d.srej_ok = s_q.ctrl_srej && rx_frame.has_cfg && rx_frame.srej_cap;
        s_d.pend_ua = 1'b1;
        s_d.ua_up   = 1'b1;
        s_d.con_t   = '0;
        if (s_q.lstate == LNK_UP)
        begin
          s_d.lstate     = LNK_WAIT;
          s_d.link_reset = 1'b1;
        end
      end
    end
    else if (rx_valid && s_q.lstate == LNK_WAIT && rx_frame.kind == KIND_U
             && rx_frame.umod == UM_UA)
    begin
      // R12 sender comes up on UA
      s_d.lstate  = LNK_UP;
      s_d.win     = s_q.ctrl_win;
      s_d.srej_ok = 1'b0;
      s_d.con_t   = '0;
      s_d.ua_up   = 1'b0;
    end
    // R13 nothing else counts before the link is up
    else if (rx_valid && s_q.lstate == LNK_UP && rx_frame.kind != KIND_U)
    begin
      // R7 R8 update oldest unacknowledged
      if (in_win(s_q.dnr, rx_frame.nr, 3'(s_q.ns + 3'h1)))
      begin
        s_d.dnr = rx_frame.nr;
        if (rx_frame.nr != s_q.dnr)
          s_d.grd_t = TMR_W'(GUARD_CYC_P);
        if (rx_frame.nr == s_q.ns)
          s_d.grd_t = '0;
      end
      else
      begin
        // R11 out-of-window ack cannot be recovered
        s_d.lstate     = LNK_WAIT;
        s_d.pend_rset  = 1'b1;
        s_d.link_reset = 1'b1;
        s_d.txq        = '0;
      end
      if (rx_frame.kind == KIND_I)
      begin
        if (rx_frame.ns == s_q.nr)
        begin
          // R26 in-order accept
          s_d.nr         = 3'(s_q.nr + 3'h1);
          s_d.rx_deliver = 1'b1;
          s_d.rr_rpt     = 1'b0;
          s_d.rr_t       = '0;
          // R17 first frame since last ack starts timer
          if (s_q.ack_t == '0)
            s_d.ack_t = ack_lim;
        end
        else
        begin
          // R18 gap: reject naming first missing frame
          s_d.pend_s = 1'b1;
          if (s_q.srej_ok && rx_frame.ns == 3'(s_q.nr + 3'h1))
            s_d.pend_stype = ST_SREJ;
          else
            s_d.pend_stype = ST_REJ;
        end
      end
      else
      begin
        // R23 supervisory type decode
        case (rx_frame.stype)
          ST_RNR:
            s_d.peer_busy = 1'b1;
          ST_RR:
          begin
            s_d.peer_busy = 1'b0;
            // R21 confirm resume with empty I-frame
            if (s_q.peer_busy && s_q.txq == '0 && s_q.ns == s_q.top)
              s_d.pend_empty = 1'b1;
          end
          default:
            s_d.ns = rx_frame.nr;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // Timers
    // ----------------------------------------------------------------
    // R4 no answer: retry reset
    if (s_q.con_t == TMR_W'(1) && s_q.lstate == LNK_WAIT)
      s_d.pend_rset = 1'b1;
    // R3 guard expiry: go back to oldest
    if (s_q.grd_t == TMR_W'(1) && s_q.lstate == LNK_UP)
      s_d.ns = s_d.dnr;
    // R17 ack timeout sends RR
    if (s_q.ack_t == TMR_W'(1) && s_q.lstate == LNK_UP && !s_d.pend_s)
    begin
      s_d.pend_s     = 1'b1;
      s_d.pend_stype = ST_RR;
    end
    // R20 resume RR repeated until an in-order I-frame is accepted
    if (s_q.lstate == LNK_UP && s_q.busy_prev && !s_q.ctrl_busy)
    begin
      s_d.rr_rpt     = 1'b1;
      s_d.rr_t       = TMR_W'(RR_CYC_P);
      s_d.pend_s     = 1'b1;
      s_d.pend_stype = ST_RR;
    end
    else if (s_q.rr_rpt && s_q.rr_t == TMR_W'(1))
    begin
      s_d.rr_t       = TMR_W'(RR_CYC_P);
      s_d.pend_s     = 1'b1;
      s_d.pend_stype = ST_RR;
    end

    // ----------------------------------------------------------------
    // Transmit launch: unnumbered, then supervisory, then information
    // ----------------------------------------------------------------
    if (!s_q.tx_valid)
    begin
      s_d.tx_frame    = '0;
      s_d.tx_frame.nr = s_d.nr;
      s_d.tx_frame.ns = s_q.ns;
      if (s_q.pend_rset)
      begin
        // R15 R24 R25 reset offers window and capability together
        s_d.tx_valid          = 1'b1;
        s_d.tx_frame.kind     = KIND_U;
        s_d.tx_frame.umod     = UM_RSET;
        s_d.tx_frame.has_cfg  = 1'b1;
        s_d.tx_frame.win      = s_q.ctrl_win;
        s_d.tx_frame.srej_cap = s_q.ctrl_srej;
        s_d.pend_rset         = 1'b0;
        // R9 clear sequence state for the new session
        s_d.ns = '0;
        s_d.nr = '0;
        s_d.dnr = '0;
        s_d.top = '0;
      end
      else if (s_q.pend_ua)
      begin
        s_d.tx_valid      = 1'b1;
        s_d.tx_frame.kind = KIND_U;
        s_d.tx_frame.umod = UM_UA;
        s_d.pend_ua       = 1'b0;
        s_d.ns = '0;
        s_d.nr = '0;
        s_d.dnr = '0;
        s_d.top = '0;
      end
      else if (s_q.lstate == LNK_UP && s_q.pend_s)
      begin
        // R6 R20 carry nr; RNR while locally busy
        s_d.tx_valid       = 1'b1;
        s_d.tx_frame.kind  = KIND_S;
        s_d.tx_frame.stype = (s_q.ctrl_busy && s_q.pend_stype == ST_RR) ? ST_RNR
                                                                       : s_q.pend_stype;
        if (!s_d.pend_s || s_q.pend_s)
          s_d.pend_s = (s_d.pend_stype != s_q.pend_stype) ? 1'b1 : 1'b0;
      end
      // R27 window full stops new frames
      else if (s_q.lstate == LNK_UP && !s_q.peer_busy && outstanding < s_q.win
               && (s_q.ns != s_q.top || s_q.txq != '0 || s_q.pend_empty))
      begin
        s_d.tx_valid       = 1'b1;
        s_d.tx_frame.kind  = KIND_I;
        s_d.tx_frame.empty = (s_q.ns == s_q.top) && (s_q.txq == '0);
      end
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      // R1 default window of four
      s_q          <= '0;
      s_q.win      <= DEF_WIN;
      s_q.ctrl_win <= CTRL_WIN_RST;
    end
    else
      s_q <= s_d;
  end

  assign wb_dat_o   = s_q.wb_dat;
  assign wb_ack_o   = s_q.wb_ack;
  assign tx_valid   = s_q.tx_valid;
  assign tx_frame   = s_q.tx_frame;
  assign rx_deliver = s_q.rx_deliver;
  assign link_reset = s_q.link_reset;
  assign link_state = s_q.lstate;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ns_after_emit: assert property (@(posedge clock) disable iff (!nrst) // R5
    (s_q.tx_valid && tx_ready && s_q.tx_frame.kind == KIND_I)
      |=> s_q.ns == 3'($past(s_q.ns) + 3'h1))
    else $error("send number not bumped after I-frame");

  a_drop_before_up: assert property (@(posedge clock) disable iff (!nrst) // R13
    (rx_valid && s_q.lstate != LNK_UP && rx_frame.kind == KIND_I) |=> !s_q.rx_deliver)
    else $error("frame delivered before link up");

  a_window_full: assert property (@(posedge clock) disable iff (!nrst) // R27
    ($rose(s_q.tx_valid) && s_q.tx_frame.kind == KIND_I)
      |-> $past(3'(s_q.ns - s_q.dnr)) < s_q.win)
    else $error("I-frame launched with full window");

  a_up_seq_clear: assert property (@(posedge clock) disable iff (!nrst) // R9
    ($rose(s_q.lstate == LNK_UP) && $past(s_q.lstate) == LNK_WAIT)
      |-> s_q.nr == '0 && s_q.dnr == '0 && s_q.ns == '0)
    else $error("sequence numbers not cleared at link up");

  a_gap_reject: assert property (@(posedge clock) disable iff (!nrst) // R18
    (rx_valid && s_q.lstate == LNK_UP && rx_frame.kind == KIND_I
     && rx_frame.ns != s_q.nr && !s_q.srej_ok && in_win(s_q.dnr, rx_frame.nr,
     3'(s_q.ns + 3'h1)))
      |=> s_q.pend_stype == ST_REJ && (s_q.pend_s || $rose(s_q.tx_valid)))
    else $error("no reject after sequence gap");

  a_ack_start: assert property (@(posedge clock) disable iff (!nrst) // R17
    (rx_valid && s_q.lstate == LNK_UP && rx_frame.kind == KIND_I
     && rx_frame.ns == s_q.nr && s_q.ack_t == '0 && !(s_q.tx_valid && tx_ready)
     && in_win(s_q.dnr, rx_frame.nr, 3'(s_q.ns + 3'h1)))
      |=> s_q.ack_t == $past(ack_lim))
    else $error("ack timer not started on first frame");

  a_connect_rset: assert property (@(posedge clock) disable iff (!nrst) // R10
    (s_q.wb_ack && $past(wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]
     && wb_dat_i[CTRL_CONNECT]))
      |-> s_q.pend_rset || (s_q.tx_valid && s_q.tx_frame.umod == UM_RSET))
    else $error("connect did not queue a reset frame");

  a_ua_on_reset: assert property (@(posedge clock) disable iff (!nrst) // R12
    (rx_valid && rx_frame.kind == KIND_U && rx_frame.umod == UM_RSET
     && s_q.ctrl_win >= peer_win && !s_q.pend_ua && !s_q.tx_valid && !s_q.pend_rset
     && !s_q.pend_s && s_q.txq == '0 && !s_q.pend_empty && s_q.ns == s_q.top)
      |-> ##2 (s_q.tx_valid && s_q.tx_frame.umod == UM_UA))
    else $error("acceptable reset not answered with UA");

  a_wb_ack_pulse: assert property (@(posedge clock) disable iff (!nrst) // R1
    s_q.wb_ack |=> !s_q.wb_ack ##1 (s_q.lstate != LNK_UP || $stable(s_q.win)
      || $past(rx_valid)))
    else $error("bus ack held or window changed in session");

endmodule

/* File: verilog/swl_pkg.sv */
// Shared constants and types for the sliding-window link endpoint
package swl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int CYC_PER_US    = CLK_HZ / 1_000_000;
  // Acknowledge time for a full window of four, scaled by w/4
  localparam int ACK_TIME_US   = 5000;
  localparam int ACK_CYC       = ACK_TIME_US * CYC_PER_US;
  // Retransmit guard is a least time: exact count
  localparam int GUARD_TIME_US = 10000;
  localparam int GUARD_CYC     = GUARD_TIME_US * CYC_PER_US;
  // Connect time must stay strictly below the figure
  localparam int CONN_TIME_US  = 5000;
  localparam int CONN_CYC      = CONN_TIME_US * CYC_PER_US - 1;
  // Resume RR repeat period, lower end of the allowed span
  localparam int RR_RPT_US     = 5000;
  localparam int RR_RPT_CYC    = RR_RPT_US * CYC_PER_US;
  localparam int TMR_W         = 20;

  // ----------------------------------------------------------------
  // Frame coding
  // ----------------------------------------------------------------
  localparam logic [2:0] DEF_WIN  = 3'h4;
  localparam logic [2:0] MIN_WIN  = 3'h2;
  localparam logic [1:0] ST_RR    = 2'h0;
  localparam logic [1:0] ST_REJ   = 2'h1;
  localparam logic [1:0] ST_RNR   = 2'h2;
  localparam logic [1:0] ST_SREJ  = 2'h3;
  localparam logic [4:0] UM_RSET  = 5'h19;
  localparam logic [4:0] UM_UA    = 5'h06;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_TXQ      = 8'h04;
  localparam logic [7:0]  REG_STAT     = 8'h08;
  localparam int          CTRL_CONNECT = 0;
  localparam int          CTRL_BUSY    = 1;
  localparam int          CTRL_WIN_LSB = 2;
  localparam int          CTRL_SREJ    = 5;
  localparam int          CTRL_FE      = 6;
  localparam logic [2:0]  CTRL_WIN_RST = 3'h4;

  typedef enum logic [1:0] {
    LNK_IDLE = 2'b00,
    LNK_WAIT = 2'b01,
    LNK_UP   = 2'b11
  } swl_link_e;

  typedef enum logic [1:0] {
    KIND_I = 2'b00,
    KIND_S = 2'b01,
    KIND_U = 2'b10
  } swl_kind_e;

  typedef struct packed {
    swl_kind_e  kind;
    logic [2:0] ns;
    logic [2:0] nr;
    logic [1:0] stype;
    logic [4:0] umod;
    logic       has_cfg;
    logic [2:0] win;
    logic       srej_cap;
    logic       empty;
  } swl_frame_s;

endpackage
